// File: irq_flag_pkg.sv
// Package: bit positions, reset values and host access codes for the interrupt flag block
package irq_flag_pkg;
    // Enable and flag bit positions (shared by both registers)
    localparam int BIT_GLOBAL = 15;
    localparam int BIT_EXPONENT = 14;
    localparam int BIT_HASH = 13;
    localparam int BIT_CIPHER = 12;
    localparam int BIT_LINK = 11;
    localparam int BIT_PACKET = 6;
    localparam int BIT_COPY = 5;
    localparam int BIT_RESV4 = 4;
    localparam int BIT_TX_DONE = 3;
    localparam int BIT_TX_ABORT = 2;
    localparam int BIT_RX_ABORT = 1;
    localparam int BIT_CNT_FULL = 0;
    // Reset values
    localparam logic [15:0] ENABLES_RESET = 16'h8010;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    // Writable bits of each register
    localparam logic [15:0] ENABLES_WMASK = 16'hF86F;
    localparam logic [15:0] FLAGS_WMASK = 16'h782E;
    // Received frame counter limit
    localparam logic [7:0] COUNTER_MAX = 8'hFF;
    // Host register select and access operation
    localparam logic SEL_FLAGS = 1'b0;
    localparam logic SEL_ENABLES = 1'b1;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_WRITE = 2'b01,
        OP_SET = 2'b10,
        OP_CLEAR = 2'b11
    } access_op_t;
endpackage

// File: irq_flag_enable.sv
// Interrupt flag and enable logic of the Ethernet controller
module irq_flag_enable (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Host register access
    input wire logic reg_sel,
    input wire irq_flag_pkg::access_op_t reg_op,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] interrupt_flags,
    output logic [15:0] interrupt_enables,
    // Engine start bits of the primary control register
    input wire logic exponent_start_bit,
    input wire logic cipher_start_bit,
    input wire logic copy_engine_start_bit,
    // Engine and receive events, same clock
    input wire logic hash_done_pulse,
    input wire logic tx_done_pulse,
    input wire logic tx_abort_pulse,
    input wire logic rx_drop_no_room,
    input wire logic rx_frame_arrived,
    input wire logic link_up,
    input wire logic [7:0] received_frame_counter,
    // Interrupt toward the host
    output logic irq_out
);
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] enables;
        logic exp_prev;
        logic cipher_prev;
        logic copy_prev;
        logic link_prev;
        logic [7:0] cnt_prev;
        logic irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [15:0] set_ev;
    logic [15:0] host_clr;
    logic [15:0] host_set;
    logic [15:0] wmask;

    always_comb begin
        st_nxt = st_r;
        set_ev = 16'h0000;
        set_ev[irq_flag_pkg::BIT_EXPONENT] = st_r.exp_prev & ~exponent_start_bit;
        set_ev[irq_flag_pkg::BIT_HASH] = hash_done_pulse;
        set_ev[irq_flag_pkg::BIT_CIPHER] = st_r.cipher_prev & ~cipher_start_bit;
        set_ev[irq_flag_pkg::BIT_LINK] = st_r.link_prev ^ link_up;
        set_ev[irq_flag_pkg::BIT_COPY] = st_r.copy_prev & ~copy_engine_start_bit;
        set_ev[irq_flag_pkg::BIT_TX_DONE] = tx_done_pulse;
        set_ev[irq_flag_pkg::BIT_TX_ABORT] = tx_abort_pulse;
        set_ev[irq_flag_pkg::BIT_RX_ABORT] = rx_drop_no_room | (rx_frame_arrived
            & (received_frame_counter == irq_flag_pkg::COUNTER_MAX));
        // Host side edits; flag writes only touch writable bits
        wmask = (reg_sel == irq_flag_pkg::SEL_FLAGS) ? irq_flag_pkg::FLAGS_WMASK
                                                    : irq_flag_pkg::ENABLES_WMASK;
        host_set = 16'h0000;
        host_clr = 16'h0000;
        unique case (reg_op)
            irq_flag_pkg::OP_NONE: begin
            end
            irq_flag_pkg::OP_WRITE: begin
                host_set = reg_wdata & wmask;
                host_clr = ~reg_wdata & wmask;
            end
            irq_flag_pkg::OP_SET: begin
                host_set = reg_wdata & wmask;
            end
            irq_flag_pkg::OP_CLEAR: begin
                host_clr = reg_wdata & wmask;
            end
        endcase
        if (reg_sel == irq_flag_pkg::SEL_ENABLES) begin
            st_nxt.enables = (st_r.enables & ~host_clr) | host_set;
            // Reserved bit 4 reads one and cannot be written
            st_nxt.enables[irq_flag_pkg::BIT_RESV4] = 1'b1;
        end else begin
            // Event set beats a host clear in the same cycle; no auto clear
            st_nxt.flags = (st_r.flags & ~host_clr) | host_set | set_ev;
        end
        if (reg_sel == irq_flag_pkg::SEL_ENABLES) begin
            st_nxt.flags = st_r.flags | set_ev;
        end
        // Counter-driven flags are hardware owned
        st_nxt.flags[irq_flag_pkg::BIT_PACKET] = (received_frame_counter != 8'h00);
        if (received_frame_counter == irq_flag_pkg::COUNTER_MAX
            && st_r.cnt_prev != irq_flag_pkg::COUNTER_MAX) begin
            st_nxt.flags[irq_flag_pkg::BIT_CNT_FULL] = 1'b1;
        end else if (received_frame_counter < st_r.cnt_prev) begin
            st_nxt.flags[irq_flag_pkg::BIT_CNT_FULL] = 1'b0;
        end else begin
            st_nxt.flags[irq_flag_pkg::BIT_CNT_FULL] = st_r.flags[irq_flag_pkg::BIT_CNT_FULL];
        end
        st_nxt.exp_prev = exponent_start_bit;
        st_nxt.cipher_prev = cipher_start_bit;
        st_nxt.copy_prev = copy_engine_start_bit;
        st_nxt.link_prev = link_up;
        st_nxt.cnt_prev = received_frame_counter;
        // Output from registered state, one cycle behind flag updates
        st_nxt.irq = st_r.enables[irq_flag_pkg::BIT_GLOBAL]
            & (|(st_r.flags & st_r.enables & 16'h7FEF));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.enables <= irq_flag_pkg::ENABLES_RESET;
            st_r.flags <= irq_flag_pkg::FLAGS_RESET;
            // Prime start bit and link edge detectors so a level held through reset is not an edge; cnt_prev resets to zero
            st_r.exp_prev <= exponent_start_bit;
            st_r.cipher_prev <= cipher_start_bit;
            st_r.copy_prev <= copy_engine_start_bit;
            st_r.link_prev <= link_up;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign interrupt_flags = st_r.flags;
    assign interrupt_enables = st_r.enables;
    assign irq_out = st_r.irq;

    // Assertions
    exp_edge_a: assert property (@(posedge clk) disable iff (srst)
        $fell(exponent_start_bit) |=> interrupt_flags[irq_flag_pkg::BIT_EXPONENT])
        else $error("exponent done flag not set");
    cipher_edge_a: assert property (@(posedge clk) disable iff (srst)
        $fell(cipher_start_bit) |=> interrupt_flags[irq_flag_pkg::BIT_CIPHER])
        else $error("cipher done flag not set");
    copy_edge_a: assert property (@(posedge clk) disable iff (srst)
        $fell(copy_engine_start_bit) |=> interrupt_flags[irq_flag_pkg::BIT_COPY])
        else $error("copy done flag not set");
    hash_set_a: assert property (@(posedge clk) disable iff (srst)
        hash_done_pulse |=> interrupt_flags[irq_flag_pkg::BIT_HASH])
        else $error("hash done flag not set");
    link_set_a: assert property (@(posedge clk) disable iff (srst)
        !$stable(link_up) |=> interrupt_flags[irq_flag_pkg::BIT_LINK])
        else $error("link change flag not set");
    rx_abort_a: assert property (@(posedge clk) disable iff (srst)
        rx_drop_no_room |=> interrupt_flags[irq_flag_pkg::BIT_RX_ABORT])
        else $error("receive abort flag not set");
    pkt_pending_a: assert property (@(posedge clk) disable iff (srst)
        ##1 interrupt_flags[irq_flag_pkg::BIT_PACKET] == ($past(received_frame_counter) != 8'h00))
        else $error("packet pending mismatch");
    cnt_full_a: assert property (@(posedge clk) disable iff (srst)
        (received_frame_counter == irq_flag_pkg::COUNTER_MAX
            && $past(received_frame_counter) != irq_flag_pkg::COUNTER_MAX)
        |=> interrupt_flags[irq_flag_pkg::BIT_CNT_FULL])
        else $error("counter full flag not set");
    flag_sticky_a: assert property (@(posedge clk) disable iff (srst)
        (interrupt_flags[irq_flag_pkg::BIT_HASH] && reg_op == irq_flag_pkg::OP_NONE)
        |=> interrupt_flags[irq_flag_pkg::BIT_HASH])
        else $error("flag cleared without host");
    global_gate_a: assert property (@(posedge clk) disable iff (srst)
        !interrupt_enables[irq_flag_pkg::BIT_GLOBAL] |=> !irq_out)
        else $error("interrupt with global enable off");
    irq_cause_a: assert property (@(posedge clk) disable iff (srst)
        ##1 irq_out == ($past(interrupt_enables[irq_flag_pkg::BIT_GLOBAL])
            && |($past(interrupt_flags) & $past(interrupt_enables) & 16'h7FEF)))
        else $error("interrupt output mismatch");
    cnt_clear_a: assert property (@(posedge clk) disable iff (srst)
        (received_frame_counter < $past(received_frame_counter))
        |=> !interrupt_flags[irq_flag_pkg::BIT_CNT_FULL])
        else $error("counter full flag kept after decrement");
    exp_sticky_a: assert property (@(posedge clk) disable iff (srst)
        (interrupt_flags[irq_flag_pkg::BIT_EXPONENT]
            && !(reg_sel == irq_flag_pkg::SEL_FLAGS && reg_op != irq_flag_pkg::OP_NONE))
        |=> interrupt_flags[irq_flag_pkg::BIT_EXPONENT])
        else $error("exponent done flag cleared without host");
    set_wins_a: assert property (@(posedge clk) disable iff (srst)
        (hash_done_pulse && reg_sel == irq_flag_pkg::SEL_FLAGS
            && reg_op == irq_flag_pkg::OP_CLEAR && reg_wdata[irq_flag_pkg::BIT_HASH])
        |=> interrupt_flags[irq_flag_pkg::BIT_HASH])
        else $error("host clear beat a hash done event");
    // Clear without a competing event must take effect
    sequence hash_clear_s;
        reg_sel == irq_flag_pkg::SEL_FLAGS && reg_op == irq_flag_pkg::OP_CLEAR
            && reg_wdata[irq_flag_pkg::BIT_HASH] && !hash_done_pulse;
    endsequence
    host_clear_a: assert property (@(posedge clk) disable iff (srst)
        hash_clear_s |=> !interrupt_flags[irq_flag_pkg::BIT_HASH])
        else $error("hash done flag survived a host clear");
    // Saturated drop takes two steps: counter sits at maximum, then a frame lands
    sequence counter_at_max_s;
        received_frame_counter == irq_flag_pkg::COUNTER_MAX;
    endsequence
    sequence frame_at_max_s;
        rx_frame_arrived && received_frame_counter == irq_flag_pkg::COUNTER_MAX;
    endsequence
    sat_drop_a: assert property (@(posedge clk) disable iff (srst)
        counter_at_max_s ##1 frame_at_max_s |=> interrupt_flags[irq_flag_pkg::BIT_RX_ABORT]
            && interrupt_flags[irq_flag_pkg::BIT_CNT_FULL])
        else $error("saturated drop not flagged");
    // Engine finish is two steps: start bit seen high, then cleared by the engine
    sequence copy_finish_s;
        copy_engine_start_bit ##1 !copy_engine_start_bit;
    endsequence
    copy_finish_a: assert property (@(posedge clk) disable iff (srst)
        copy_finish_s |=> interrupt_flags[irq_flag_pkg::BIT_COPY])
        else $error("copy done flag missed after engine finish");
    // Unused positions hold fixed values, enable bit 4 at one and the rest at zero, so software can test the whole word
    reserved_bits_a: assert property (@(posedge clk) disable iff (srst)
        (interrupt_flags & 16'h8790) == 16'h0000
            && (interrupt_enables & 16'h0790) == 16'h0010)
        else $error("reserved bit out of place");
    enable_gate_a: assert property (@(posedge clk) disable iff (srst)
        (interrupt_flags & interrupt_enables & 16'h7FEF) == 16'h0000 |=> !irq_out)
        else $error("interrupt from a disabled source");
endmodule // irq_flag_enable

// File: host_model.sv
// Host model that drives the register access port of the flag block
module host_model (
    // Clock
    input wire logic clk,
    // Register access
    output logic reg_sel,
    output irq_flag_pkg::access_op_t reg_op,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_sel = 1'b0;
        reg_op = irq_flag_pkg::OP_NONE;
        reg_wdata = 16'h0000;
    end
    // One op per call, dropped again so that it is never taken twice
    task automatic access(input logic s, input irq_flag_pkg::access_op_t o, input logic [15:0] d);
        @(negedge clk);
        reg_sel = s;
        reg_op = o;
        reg_wdata = d;
        @(negedge clk);
        reg_op = irq_flag_pkg::OP_NONE;
    endtask
    // Bit clear only; a full write could lose a flag raised meanwhile
    task automatic clear_flags(input logic [15:0] m);
        access(irq_flag_pkg::SEL_FLAGS, irq_flag_pkg::OP_CLEAR, m);
    endtask
endmodule // host_model

// File: ethernet_interrupt_flag_enable_test.sv
// Self-checking bench of the interrupt flag and enable block
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module ethernet_interrupt_flag_enable_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic EN = irq_flag_pkg::SEL_ENABLES;
    localparam irq_flag_pkg::access_op_t WR = irq_flag_pkg::OP_WRITE;
    localparam irq_flag_pkg::access_op_t CL = irq_flag_pkg::OP_CLEAR;
    logic clk = 1'b0, srst = 1'b1, rs, irq, ex = 1'b0, ci = 1'b0, cp = 1'b0, hs = 1'b0;
    logic td = 1'b0, ta = 1'b0, dr = 1'b0, ar = 1'b0, lk = 1'b0;
    logic [15:0] wd, fl, en;
    logic [7:0] cnt = 8'h00;
    logic [15:0] m;
    irq_flag_pkg::access_op_t op;
    int n_fail = 0, tests_run = 0;
    int bits[8] = '{13, 3, 2, 1, 14, 12, 5, 11};
    always #4 clk = ~clk;
    host_model h (.clk(clk), .reg_sel(rs), .reg_op(op), .reg_wdata(wd));
    irq_flag_enable dut_u (.clk(clk), .srst(srst), .reg_sel(rs), .reg_op(op), .reg_wdata(wd),
        .interrupt_flags(fl), .interrupt_enables(en), .exponent_start_bit(ex),
        .cipher_start_bit(ci), .copy_engine_start_bit(cp), .hash_done_pulse(hs),
        .tx_done_pulse(td), .tx_abort_pulse(ta), .rx_drop_no_room(dr), .rx_frame_arrived(ar),
        .link_up(lk), .received_frame_counter(cnt), .irq_out(irq));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start bits go high then low, so the source sees a falling edge
    task automatic fire(input int k);
        @(negedge clk);
        case (k)
            0: hs = 1'b1; 1: td = 1'b1; 2: ta = 1'b1; 3: dr = 1'b1;
            4: ex = 1'b1; 5: ci = 1'b1; 6: cp = 1'b1; default: lk = ~lk;
        endcase
        @(negedge clk);
        {hs, td, ta, dr, ex, ci, cp} = 7'h00;
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(2);
        srst = 1'b0;
        `CHK("enables", irq_flag_pkg::ENABLES_RESET, en)
        `CHK("flags", irq_flag_pkg::FLAGS_RESET, fl)
        $display("test reset done");
        foreach (bits[k]) begin
            m = 16'h0001 << bits[k];
            h.access(EN, WR, 16'h8000 | m);
            fire(k);
            cyc(3);
            `CHK("flags", m, fl)
            `CHK("irq", 1'b1, irq)
            h.access(EN, CL, m);
            cyc(1);
            `CHK("irq", 1'b0, irq)
            h.access(EN, WR, m);
            cyc(1);
            `CHK("irq", 1'b0, irq)
            `CHK("flags", m, fl)
            h.clear_flags(m);
            `CHK("flags", 16'h0000, fl)
        end
        $display("test sources done");
        h.access(EN, WR, 16'h8043);
        cnt = 8'h01;
        cyc(2);
        h.clear_flags(16'h0040);
        `CHK("flags", 16'h0040, fl)
        `CHK("irq", 1'b1, irq)
        cnt = 8'hFF;
        cyc(2);
        `CHK("flags", 16'h0041, fl)
        ar = 1'b1;
        cyc(1);
        ar = 1'b0;
        cyc(2);
        `CHK("flags", 16'h0043, fl)
        cnt = 8'hFE;
        cyc(2);
        `CHK("flags", 16'h0042, fl)
        cnt = 8'h00;
        cyc(2);
        `CHK("flags", 16'h0002, fl)
        h.access(EN, WR, 16'hFFFF);
        `CHK("enables", 16'hF87F, en)
        $display("test counter done");
        h.access(irq_flag_pkg::SEL_FLAGS, irq_flag_pkg::OP_SET, 16'hFFFF);
        `CHK("flags", irq_flag_pkg::FLAGS_WMASK, fl)
        hs = 1'b1;
        h.clear_flags(16'hFFFF);
        hs = 1'b0;
        `CHK("flags", 16'h2000, fl)
        h.clear_flags(16'h2000);
        `CHK("flags", 16'h0000, fl)
        $display("test host edits done");
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        `CHK("enables", irq_flag_pkg::ENABLES_RESET, en)
        `CHK("irq", 1'b0, irq)
        cyc(2);
        `CHK("flags", irq_flag_pkg::FLAGS_RESET, fl)
        h.access(EN, CL, 16'hFFFF);
        `CHK("enables", 16'h0010, en)
        h.access(EN, irq_flag_pkg::OP_SET, 16'h8000);
        `CHK("enables", 16'h8010, en)
        $display("test reset again done");
        test_done();
    end
    initial begin
        #(8 * 5000);
        n_fail++;
        test_done();
    end
endmodule // ethernet_interrupt_flag_enable_test
